// ===== include/t3sc_defines.vh
`ifndef T3SC_DEFINES_VH
`define T3SC_DEFINES_VH
// ----------------------------------------------------------------------------
// Register byte addresses on the bus (one aligned word each).
// ----------------------------------------------------------------------------
`define T3SC_ADDR_LOW 8'h00
`define T3SC_ADDR_HIGH 8'h04
`define T3SC_ADDR_CTRL 8'h08
`define T3SC_ADDR_STAT 8'h0C
// ----------------------------------------------------------------------------
// Control register field positions.
// ----------------------------------------------------------------------------
`define T3SC_BIT_WIDE 7
`define T3SC_BIT_CSEL_HI 6
`define T3SC_BIT_PS_HI 5
`define T3SC_BIT_PS_LO 4
`define T3SC_BIT_CSEL_LO 3
`define T3SC_BIT_BYPASS 2
`define T3SC_BIT_SRC 1
`define T3SC_BIT_RUN 0
// ----------------------------------------------------------------------------
// Status register fields: overflow flag, irq enable, oscillator enable.
// ----------------------------------------------------------------------------
`define T3SC_BIT_OVF 0
`define T3SC_BIT_IRQEN 1
`define T3SC_BIT_OSCEN 2
`define T3SC_CTRL_RESET 8'h00
`define T3SC_MODE_TRIGGER 4'hB
`define T3SC_COUNT_MAX 16'hFFFF
`endif

// ===== rtl/t3sc_sync2.v
`timescale 1ns/10ps
// Two-stage synchroniser for a level coming from outside the clock domain.
module t3sc_sync2 (
    input wire ref_clk_i,
    input wire rst_i,
    input wire d_i,
    output wire q_o
);
    reg meta_ff;
    reg sync_ff;

    // The first stage feeds only the second stage.
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end
    assign q_o = sync_ff;
endmodule

// ===== rtl/t3sc_prescale.v
`timescale 1ns/10ps
`include "t3sc_defines.vh"
// Divides a stream of count ticks by 1, 2, 4 or 8.
module t3sc_prescale (
    input wire ref_clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire clear_i,
    input wire tick_i,
    input wire [1:0] sel_i,
    output wire inc_o
);
    reg [2:0] cnt_ff;
    reg [2:0] mask;

    // Ratio mask: all masked bits must be set for the tick to pass.
    always @* begin
        case (sel_i)
            2'h0: mask = 3'h0;
            2'h1: mask = 3'h1;
            2'h2: mask = 3'h3;
            default: mask = 3'h7;
        endcase
    end

    assign inc_o = tick_i & ((cnt_ff & mask) == mask); // R03

    // Low-byte writes restart the division so the first period is whole.
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 3'h0;
        end else if (ce_i) begin
            if (clear_i) begin
                cnt_ff <= 3'h0; // R11
            end else if (tick_i) begin
                cnt_ff <= (inc_o) ? 3'h0 : cnt_ff + 3'h1; // R03
            end
        end
    end
endmodule

// ===== rtl/t3sc_timer.v
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`include "t3sc_defines.vh"
// Notes on behaviour
// R01: Wide access bit set gives atomic 16-bit access; clear gives two byte accesses.
// R02: Capture select 1x: both units use this timer; 01: unit two only; 00: none.
// R03: Prescale field 00..11 divides count clock by 1, 2, 4, 8.
// R04: External mode: bypass bit set skips synchroniser unless oscillator enabled; ignored in internal mode.
// R05: Source bit clear counts instruction ticks; set counts rising edges after a fall.
// R06: Run bit set counts; clear holds the value.
// R07: Oscillator enabled forces its two pins to inputs reading zero.
// R08: Wide mode: low-byte read copies live high byte into the buffer.
// R09: Wide mode: high writes fill buffer; low write loads both bytes together.
// R10: Wide mode: counter high byte reachable only through the buffer.
// R11: High-byte writes keep the prescaler; low-byte writes clear it.
// R12: Counts 0000h to FFFFh, wraps, sets sticky flag, irq when enabled.
// R13: Compare unit two trigger mode with match resets the counter.
// R14: Software uses timer or synchronous mode for trigger reset.
// R15: A counter write in the trigger cycle wins over the reset.
// R16: Trigger reset never sets the overflow flag.
// R17: Software enables oscillator and external source to count from it.
// R18: Control and count reset to zero; flag holds until software clears.
module t3sc_timer (
    input wire ref_clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire hsel_i,
    input wire hready_i,
    input wire [31:0] hwdata_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    input wire ext_count_i,
    input wire osc_clk_i,
    input wire [1:0] port_direction_bits_i,
    input wire [1:0] osc_pin_level_i,
    input wire unit_two_mode_match_i,
    input wire [3:0] compare_unit_mode_i,
    output reg [1:0] osc_pin_oe_o,
    output reg [1:0] osc_pin_read_o,
    output reg unit_one_uses_this_o,
    output reg unit_two_uses_this_o,
    output reg [15:0] count_o,
    output reg overflow_irq_o,
    output reg count_inc_o
);
    // ------------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------------
    reg [7:0] ctrl_ff;
    reg [7:0] low_ff;
    reg [7:0] high_ff;
    reg [7:0] high_buf_ff;
    reg ovf_ff;
    reg irq_en_ff;
    reg osc_en_ff;
    reg wr_pend_ff;
    reg [7:0] wr_addr_ff;
    reg rd_low_ff;
    reg src_prev_ff;
    reg armed_ff;
    reg [1:0] ps_tick_ff;
    wire ext_sync;
    wire osc_sync;
    wire [1:0] pin_sync0;
    wire [1:0] pin_sync1;
    wire inc;
    wire ps_clear;
    wire wide;
    wire wr_low;
    wire wr_high;
    wire wr_ctrl;
    wire wr_stat;
    wire rise;
    wire tick;
    wire src_lvl;
    wire raw_src;
    wire trigger;
    reg [15:0] nxt_count;
    reg nxt_ovf;
    reg [7:0] nxt_high_buf;
    reg wrap;

    // Address decode shared by read and write paths.
    function [2:0] t3sc_decode;
        input [7:0] a;
        begin
            case (a)
                `T3SC_ADDR_LOW: t3sc_decode = 3'h1;
                `T3SC_ADDR_HIGH: t3sc_decode = 3'h2;
                `T3SC_ADDR_CTRL: t3sc_decode = 3'h3;
                `T3SC_ADDR_STAT: t3sc_decode = 3'h4;
                default: t3sc_decode = 3'h0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // Input synchronisers.
    // ------------------------------------------------------------------------
    t3sc_sync2 u_sync_ext (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i(ext_count_i),
        .q_o(ext_sync)
    );
    t3sc_sync2 u_sync_osc (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i(osc_clk_i),
        .q_o(osc_sync)
    );
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            t3sc_sync2 u_sync_pin (
                .ref_clk_i(ref_clk_i),
                .rst_i(rst_i),
                .d_i(osc_pin_level_i[gi]),
                .q_o(pin_sync0[gi])
            );
            assign pin_sync1[gi] = pin_sync0[gi];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Count source and edge qualification.
    // ------------------------------------------------------------------------
    // The unsynchronised path is only one register deep; that register is
    // the edge detector's history, so async mode trades metastability margin
    // for a shorter latency.
    assign raw_src = osc_en_ff ? osc_sync : ext_count_i;
    // The synchronised path must follow the oscillator too, or it would never count from it.
    assign src_lvl = ctrl_ff[`T3SC_BIT_BYPASS] ? raw_src :
        (osc_en_ff ? osc_sync : ext_sync); // R04 R05
    assign rise = src_lvl & ~src_prev_ff & armed_ff; // R05
    assign tick = ctrl_ff[`T3SC_BIT_RUN] &
        (ctrl_ff[`T3SC_BIT_SRC] ? rise : (ps_tick_ff == 2'h3)); // R05 R06
    assign wide = ctrl_ff[`T3SC_BIT_WIDE]; // R01
    assign wr_low = wr_pend_ff && (t3sc_decode(wr_addr_ff) == 3'h1);
    assign wr_high = wr_pend_ff && (t3sc_decode(wr_addr_ff) == 3'h2);
    assign wr_ctrl = wr_pend_ff && (t3sc_decode(wr_addr_ff) == 3'h3);
    assign wr_stat = wr_pend_ff && (t3sc_decode(wr_addr_ff) == 3'h4);
    assign ps_clear = wr_low; // R11
    assign trigger = unit_two_mode_match_i &&
        (compare_unit_mode_i == `T3SC_MODE_TRIGGER); // R13

    t3sc_prescale u_ps (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .clear_i(ps_clear),
        .tick_i(tick),
        .sel_i(ctrl_ff[`T3SC_BIT_PS_HI:`T3SC_BIT_PS_LO]),
        .inc_o(inc)
    );

    // Edge history and instruction-cycle divider (clock/4).
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            src_prev_ff <= 1'b1;
            armed_ff <= 1'b0;
            ps_tick_ff <= 2'h0;
        end else if (ce_i) begin
            src_prev_ff <= src_lvl;
            ps_tick_ff <= ps_tick_ff + 2'h1;
            if (!ctrl_ff[`T3SC_BIT_SRC] || !ctrl_ff[`T3SC_BIT_RUN]) begin
                armed_ff <= 1'b0; // R05
            end else if (!src_lvl && src_prev_ff) begin
                armed_ff <= 1'b1; // R05
            end
        end
    end

    // ------------------------------------------------------------------------
    // Counter next state.
    // ------------------------------------------------------------------------
    always @* begin
        nxt_count = {high_ff, low_ff};
        nxt_ovf = ovf_ff;
        nxt_high_buf = high_buf_ff;
        wrap = 1'b0;
        if (wr_low) begin
            nxt_count[7:0] = hwdata_i[7:0];
            if (wide) begin
                nxt_count[15:8] = high_buf_ff; // R09
            end
        end else if (wr_high) begin
            if (wide) begin
                nxt_high_buf = hwdata_i[7:0]; // R09 R10
            end else begin
                nxt_count[15:8] = hwdata_i[7:0];
            end
        end
        if (wr_low || (wr_high && !wide)) begin
            // Written value stands; any trigger in this cycle is dropped.
            nxt_count = nxt_count; // R15
        end else if (trigger) begin
            nxt_count = 16'h0000; // R13 R16
        end else if (inc) begin
            if (nxt_count == `T3SC_COUNT_MAX) begin
                nxt_ovf = 1'b1; // R12
                wrap = 1'b1;
            end
            nxt_count = nxt_count + 16'h0001; // R12
        end
        if (rd_low_ff && wide) begin
            nxt_high_buf = high_ff; // R08
        end
        if (wr_stat && !hwdata_i[`T3SC_BIT_OVF]) begin
            // Software clear loses to a wrap in the same cycle.
            nxt_ovf = wrap; // R18
        end
    end

    // ------------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------------
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_ff <= `T3SC_CTRL_RESET; // R18
            low_ff <= 8'h00;
            high_ff <= 8'h00;
            high_buf_ff <= 8'h00;
            ovf_ff <= 1'b0;
            irq_en_ff <= 1'b0;
            osc_en_ff <= 1'b0;
        end else if (ce_i) begin
            {high_ff, low_ff} <= nxt_count;
            high_buf_ff <= nxt_high_buf;
            ovf_ff <= nxt_ovf;
            if (wr_ctrl) begin
                ctrl_ff <= hwdata_i[7:0];
            end
            if (wr_stat) begin
                irq_en_ff <= hwdata_i[`T3SC_BIT_IRQEN];
                osc_en_ff <= hwdata_i[`T3SC_BIT_OSCEN];
            end
        end
    end

    // ------------------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY.
    // ------------------------------------------------------------------------
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rd_low_ff <= 1'b0;
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else if (ce_i) begin
            wr_pend_ff <= 1'b0;
            rd_low_ff <= 1'b0;
            if (hsel_i && hready_i && htrans_i[1]) begin
                wr_pend_ff <= hwrite_i;
                wr_addr_ff <= haddr_i[7:0];
                if (!hwrite_i) begin
                    rd_low_ff <= (t3sc_decode(haddr_i[7:0]) == 3'h1);
                    case (t3sc_decode(haddr_i[7:0]))
                        3'h1: hrdata_o <= {24'h000000, low_ff};
                        3'h2: hrdata_o <= {24'h000000, wide ? high_buf_ff : high_ff}; // R10
                        3'h3: hrdata_o <= {24'h000000, ctrl_ff};
                        3'h4: hrdata_o <= {29'h0000000, osc_en_ff, irq_en_ff, ovf_ff};
                        default: hrdata_o <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Registered side outputs.
    // ------------------------------------------------------------------------
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_pin_oe_o <= 2'h0;
            osc_pin_read_o <= 2'h0;
            unit_one_uses_this_o <= 1'b0;
            unit_two_uses_this_o <= 1'b0;
            count_o <= 16'h0000;
            overflow_irq_o <= 1'b0;
            count_inc_o <= 1'b0;
        end else if (ce_i) begin
            // Oscillator pins become inputs reading zero while it runs.
            osc_pin_oe_o <= osc_en_ff ? 2'h0 : ~port_direction_bits_i; // R07
            osc_pin_read_o <= osc_en_ff ? 2'h0 : pin_sync1; // R07
            unit_one_uses_this_o <= ctrl_ff[`T3SC_BIT_CSEL_HI]; // R02
            unit_two_uses_this_o <= ctrl_ff[`T3SC_BIT_CSEL_HI] |
                ctrl_ff[`T3SC_BIT_CSEL_LO]; // R02
            count_o <= nxt_count;
            overflow_irq_o <= nxt_ovf & irq_en_ff; // R12
            count_inc_o <= inc;
        end
    end
endmodule

// ===== tb/t3sc_chk.sv
`timescale 1ns/10ps
`include "t3sc_defines.vh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module t3sc_chk (
    input wire ref_clk_i,
    input wire rst_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire hsel_i,
    input wire hready_i,
    input wire [31:0] hrdata_o,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire unit_two_mode_match_i,
    input wire [3:0] compare_unit_mode_i,
    input wire unit_one_uses_this_o,
    input wire unit_two_uses_this_o,
    input wire [15:0] count_o,
    input wire overflow_irq_o,
    input wire count_inc_o
);
    reg wr_ph_ff;
    reg rdl_ph_ff;
    wire take = hsel_i & hready_i & htrans_i[1];
    wire trig = unit_two_mode_match_i & (compare_unit_mode_i == `T3SC_MODE_TRIGGER);
    // Any write counts as a possible counter write; that errs on the safe side.
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ph_ff <= 1'b0;
            rdl_ph_ff <= 1'b0;
        end else begin
            wr_ph_ff <= take & hwrite_i;
            rdl_ph_ff <= take & ~hwrite_i & (haddr_i[7:0] == `T3SC_ADDR_LOW);
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not okay");
    a_count_step: assert property (count_inc_o && !$past(wr_ph_ff) && !$past(trig) |->
        count_o == $past(count_o) + 16'h1) else $error("count step wrong");
    a_count_cause: assert property ($changed(count_o) |->
        count_inc_o || $past(wr_ph_ff) || $past(trig)) else $error("count moved alone");
    a_trig_reset: assert property ($past(trig) && !$past(wr_ph_ff) |-> count_o == 16'h0)
        else $error("trigger did not reset");
    a_flag_cause: assert property ($rose(overflow_irq_o) |->
        $past(count_o) == 16'hFFFF || $past(count_o, 2) == 16'hFFFF
        || $past(wr_ph_ff) || $past(wr_ph_ff, 2)) else $error("irq without wrap");
    a_unit_pair: assert property (unit_one_uses_this_o |-> unit_two_uses_this_o)
        else $error("unit one without unit two");
    a_read_low: assert property (rdl_ph_ff |-> hrdata_o[7:0] == $past(count_o[7:0]))
        else $error("low byte read wrong");
    a_inc_gap: assert property (count_inc_o |=> !count_inc_o)
        else $error("increments too close");
    c_trig: cover property (trig);
    c_wrap: cover property ($past(count_o) == 16'hFFFF && count_o == 16'h0);
    c_unit_one: cover property (unit_one_uses_this_o);
endmodule
bind t3sc_timer t3sc_chk u_chk (.ref_clk_i, .rst_i, .haddr_i, .htrans_i, .hwrite_i, .hsel_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .unit_two_mode_match_i,
    .compare_unit_mode_i, .unit_one_uses_this_o, .unit_two_uses_this_o, .count_o,
    .overflow_irq_o, .count_inc_o);

// ===== tb/t3sc_ccp_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Compare unit two stand-in
// ----------------------------------------
module t3sc_ccp_model (
    input wire en_i,
    input wire force_i,
    input wire [3:0] mode_sel_i,
    input wire [15:0] period_i,
    input wire [15:0] count_i,
    output wire match_o,
    output wire [3:0] mode_o
);
    // Compare on the registered count, so the match moves just after an edge.
    // Force holds the match up so that a bench can collide it with a write.
    assign match_o = en_i & (force_i | (count_i == period_i));
    assign mode_o = mode_sel_i;
endmodule

// ===== tb/t3sc_timer_test.sv
`timescale 1ns/10ps
`include "t3sc_defines.vh"
module t3sc_timer_test;
    localparam [7:0] ad_lo = `T3SC_ADDR_LOW;
    localparam [7:0] ad_hi = `T3SC_ADDR_HIGH;
    localparam [7:0] ad_ct = `T3SC_ADDR_CTRL;
    localparam [7:0] ad_st = `T3SC_ADDR_STAT;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg hsel = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg ext = 1'b1;
    reg osc = 1'b1;
    reg frc = 1'b0;
    reg pen = 1'b0;
    reg [3:0] msel = 4'hB;
    wire [31:0] hrdata;
    wire hready, hresp, match, u1, u2, irq, inc;
    wire [3:0] cmode;
    wire [1:0] oe, prd;
    wire [15:0] cnt;
    integer mismatches = 0;
    integer n_compared = 0;
    integer i, n;
    reg [31:0] rd;
    reg [15:0] mx;
    // ----------------------------------------
    // Clock, design and far side
    // ----------------------------------------
    always #12.5 clk = ~clk;
    t3sc_timer dut (.ref_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hsel_i(hsel), .hready_i(hready),
        .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .ext_count_i(ext), .osc_clk_i(osc), .port_direction_bits_i(2'h0),
        .osc_pin_level_i(2'h3), .unit_two_mode_match_i(match), .compare_unit_mode_i(cmode),
        .osc_pin_oe_o(oe), .osc_pin_read_o(prd), .unit_one_uses_this_o(u1),
        .unit_two_uses_this_o(u2), .count_o(cnt), .overflow_irq_o(irq), .count_inc_o(inc));
    t3sc_ccp_model far (.en_i(pen), .force_i(frc), .mode_sel_i(msel), .period_i(16'h8),
        .count_i(cnt), .match_o(match), .mode_o(cmode));
    // Values read at an edge are the ones settled since the edge before.
    task tick(input integer k);
        repeat (k) @(posedge clk);
    endtask
    task xfer(input w, input [7:0] a, input [31:0] d);
        begin
            haddr <= {24'h0, a};
            htrans <= 2'h2;
            hwrite <= w;
            hsel <= 1'b1;
            @(posedge clk);
            while (hready !== 1'b1) @(posedge clk);
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge clk);
            while (hready !== 1'b1) @(posedge clk);
            rd = hrdata;
        end
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Mask picks the line to pulse; the other one rests high.
    task pulses(input [1:0] m, input integer k);
        repeat (k) begin
            {ext, osc} <= ~m;
            tick(8);
            {ext, osc} <= 2'h3;
            tick(8);
        end
    endtask
    task t_reset;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                xfer(1'b0, 8'(i * 4), 32'h0);
                cmp(rd, 32'h0);
            end
            cmp(oe, 32'h3);
            cmp(prd, 32'h3);
        end
    endtask
    task t_select;
        for (i = 0; i < 4; i = i + 1) begin
            xfer(1'b1, ad_ct, {i[1], 2'h0, i[0], 3'h0});
            tick(2);
            cmp(u1, i[1]);
            cmp(u2, i[1] | i[0]);
        end
    endtask
    task t_count;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                xfer(1'b1, ad_ct, {2'h0, i[1:0], 4'h5});
                xfer(1'b1, ad_lo, 32'h0);
                n = 0;
                repeat (320) begin
                    @(posedge clk);
                    n = n + inc;
                end
                cmp((n >= (80 >> i) - 1) && (n <= (80 >> i) + 1), 1);
            end
            xfer(1'b1, ad_ct, 32'h0);
            tick(2);
            mx = cnt;
            tick(40);
            cmp(cnt, mx);
        end
    endtask
    task t_wide;
        begin
            xfer(1'b1, ad_ct, 32'h80);
            xfer(1'b1, ad_hi, 32'hAB);
            xfer(1'b1, ad_lo, 32'hCD);
            tick(1);
            cmp(cnt, 32'hABCD);
            xfer(1'b1, ad_hi, 32'h55);
            tick(1);
            cmp(cnt, 32'hABCD);
            xfer(1'b0, ad_hi, 32'h0);
            cmp(rd, 32'h55);
            xfer(1'b0, ad_lo, 32'h0);
            cmp(rd, 32'hCD);
            xfer(1'b0, ad_hi, 32'h0);
            cmp(rd, 32'hAB);
            xfer(1'b1, ad_ct, 32'h0);
            xfer(1'b1, ad_hi, 32'h12);
            tick(1);
            cmp(cnt, 32'h12CD);
        end
    endtask
    task t_ovf;
        begin
            xfer(1'b1, ad_st, 32'h2);
            xfer(1'b1, ad_ct, 32'h80);
            xfer(1'b1, ad_hi, 32'hFF);
            xfer(1'b1, ad_lo, 32'hFE);
            xfer(1'b1, ad_ct, 32'h81);
            tick(60);
            cmp(irq, 1);
            xfer(1'b1, ad_ct, 32'h0);
            xfer(1'b1, ad_st, 32'h1);
            tick(2);
            cmp(irq, 0);
            xfer(1'b0, ad_st, 32'h0);
            cmp(rd[0], 1);
            xfer(1'b1, ad_st, 32'h0);
            xfer(1'b0, ad_st, 32'h0);
            cmp(rd[0], 0);
        end
    endtask
    // The timer runs from the internal tick here, as the trigger reset expects.
    task t_trig;
        begin
            xfer(1'b1, ad_lo, 32'h0);
            pen <= 1'b1;
            xfer(1'b1, ad_ct, 32'h1);
            mx = 16'h0;
            repeat (200) begin
                @(posedge clk);
                if (cnt > mx) mx = cnt;
            end
            cmp(mx, 32'h8);
            xfer(1'b0, ad_st, 32'h0);
            cmp(rd[0], 0);
            msel <= 4'hA;
            tick(60);
            cmp(cnt > 16'h8, 1);
            msel <= 4'hB;
            frc <= 1'b1;
            xfer(1'b1, ad_ct, 32'h0);
            tick(2);
            cmp(cnt, 0);
            xfer(1'b1, ad_lo, 32'h77);
            tick(1);
            cmp(cnt, 32'h77);
            tick(1);
            cmp(cnt, 0);
            frc <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    task t_ext;
        begin
            xfer(1'b1, ad_lo, 32'h0);
            xfer(1'b1, ad_ct, 32'h3);
            pulses(2'h2, 5);
            cmp(cnt, 32'h5);
            xfer(1'b1, ad_ct, 32'h7);
            pulses(2'h2, 5);
            cmp(cnt, 32'hA);
            xfer(1'b1, ad_st, 32'h4);
            tick(2);
            cmp({oe, prd}, 0);
            xfer(1'b1, ad_ct, 32'h3);
            pulses(2'h1, 4);
            cmp(cnt, 32'hE);
        end
    endtask
    task finish_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // Main sequence after four cycles of reset.
    initial begin
        tick(4);
        rst <= 1'b0;
        t_reset;
        t_select;
        t_count;
        t_wide;
        t_ovf;
        t_trig;
        t_ext;
        finish_test;
    end
    // Watchdog well beyond the few thousand cycles the sequence needs.
    initial begin
        tick(20000);
        mismatches = mismatches + 1;
        finish_test;
    end
endmodule
